// file: design/fiwr_consts.svh
// Constants of the flash in-application programming controller.
// Assumes a 250 MHz system clock and a 16-bit wide flash array.
`ifndef FIWR_CONSTS_SVH
`define FIWR_CONSTS_SVH

`define FIWR_CLK_MHZ 250
`define FIWR_PROG_TIME_US 2200
`define FIWR_UNLOCK_TIME_US 1000
`define FIWR_READ_CYC 3
`define FIWR_CNT_W 20
`define FIWR_ADDR_W 13
`define FIWR_OFS_W 5
`define FIWR_PAGE_WORDS 32
`define FIWR_MODE_WRITE 3'h0
`define FIWR_MODE_ERASE 3'h1
`define FIWR_MODE_READ 3'h3
`define FIWR_MODE_UNLOCK 3'h6
`define FIWR_KEY_PATTERN 48'h4009_04C3_0D00
`define FIWR_KEY_W 48
`define FIWR_LAST_OFS 5'h1F

`endif

// file: design/fiwr_pkg.sv
// Types of the flash in-application programming controller.
// Assumes the constants header sits beside it.
`include "fiwr_consts.svh"

package fiwr_pkg;

  typedef enum logic [1:0] {
    FIWR_IDLE,
    FIWR_ERASE,
    FIWR_PROG,
    FIWR_READ
  } fiwr_state_t;

  typedef struct packed {
    fiwr_state_t st;
    logic [`FIWR_CNT_W-1:0] cnt;
    logic [`FIWR_CNT_W-1:0] ucnt;
    logic [`FIWR_OFS_W:0] idx;
    logic [`FIWR_ADDR_W-1:0] addr;
    logic [7:0] dlo;
    logic [7:0] dhi;
    logic [`FIWR_OFS_W-1:0] ptr;
    logic [`FIWR_PAGE_WORDS-1:0] valid;
    logic [`FIWR_KEY_W-1:0] keys;
    logic unlocked;
    logic utimer;
    logic ptrig;
    logic rtrig;
  } fiwr_regs_t;

endpackage

// file: design/fiwr_wbuf.sv
// Page write buffer storage, one write port and one registered read port.
// Assumes the owner tracks which entries are loaded.
`timescale 1ns/1ps

module fiwr_wbuf
  import fiwr_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32,
  parameter int AW = 5
)
(
  input wire logic mclk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);

  // ****************************************
  // Storage
  // ****************************************
  // No reset on the array: emptiness is kept as valid bits by the owner.
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge mclk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule

// file: design/fiwr_ctrl.sv
// Flash erase, page write and word read sequencer with unlock protection.
// Assumes CPU register writes arrive as one-cycle strobes and the flash
// array answers a read combinationally within the read window.
`timescale 1ns/1ps
`include "fiwr_consts.svh"

module fiwr_ctrl
  import fiwr_pkg::*;
#(
  parameter int PROG_CYCLES = `FIWR_PROG_TIME_US * `FIWR_CLK_MHZ,
  parameter int UNLOCK_CYCLES = `FIWR_UNLOCK_TIME_US * `FIWR_CLK_MHZ
)
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [2:0] op_select_field,
  input wire logic read_enable_bit,
  input wire logic [7:0] wdata,
  input wire logic addr_high_we,
  input wire logic addr_low_we,
  input wire logic data_low_we,
  input wire logic data_high_we,
  input wire logic key_we,
  input wire logic [2:0] key_idx,
  input wire logic program_trigger_set,
  input wire logic read_trigger_set,
  input wire logic unlock_timer_set,
  input wire logic buffer_clear_set,
  input wire logic unlocked_clear,
  input wire logic [15:0] fl_rdata,
  output logic program_trigger_bit,
  output logic read_trigger_bit,
  output logic unlock_timer_bit,
  output logic programming_unlocked_flag,
  output logic [7:0] flash_addr_high_reg,
  output logic [7:0] flash_addr_low_reg,
  output logic [7:0] data_low_byte_reg,
  output logic [7:0] data_high_byte_reg,
  output logic cpu_stall,
  output logic fl_erase,
  output logic fl_prog,
  output logic fl_read,
  output logic [`FIWR_ADDR_W-1:0] fl_addr,
  output logic [15:0] fl_wdata
);

  // ****************************************
  // State and buffer
  // ****************************************
  fiwr_regs_t s;
  fiwr_regs_t next_s;
  logic [15:0] buf_rdata;
  logic buf_we;
  logic idle;
  logic [`FIWR_OFS_W-1:0] word_ofs;
  logic prog_go;
  logic erase_go;
  logic read_go;

  localparam logic [`FIWR_CNT_W-1:0] PROG_LAST = `FIWR_CNT_W'(PROG_CYCLES - 1);
  localparam logic [`FIWR_CNT_W-1:0] UNLOCK_LAST = `FIWR_CNT_W'(UNLOCK_CYCLES - 1);
  localparam logic [`FIWR_CNT_W-1:0] READ_LAST = `FIWR_CNT_W'(`FIWR_READ_CYC - 1);
  localparam logic [`FIWR_OFS_W:0] IDX_END = (`FIWR_OFS_W+1)'(`FIWR_PAGE_WORDS + 1);

  assign idle = (s.st == FIWR_IDLE);
  assign buf_we = data_high_we && idle;
  assign word_ofs = `FIWR_OFS_W'(s.idx - 1'b1);

  fiwr_wbuf #(
    .WIDTH(16),
    .DEPTH(`FIWR_PAGE_WORDS),
    .AW(`FIWR_OFS_W)
  ) u_wbuf (
    .mclk(mclk),
    .we(buf_we),
    .waddr(s.ptr),
    .wdata({wdata, s.dlo}),
    .raddr(s.idx[`FIWR_OFS_W-1:0]),
    .rdata(buf_rdata)
  );

  // ****************************************
  // Trigger qualification
  // ****************************************
  // erase and write gated by unlock
  assign prog_go = idle && program_trigger_set && s.unlocked
    && (op_select_field == `FIWR_MODE_WRITE);
  assign erase_go = idle && program_trigger_set && s.unlocked
    && (op_select_field == `FIWR_MODE_ERASE);
  assign read_go = idle && read_trigger_set && read_enable_bit
    && (op_select_field == `FIWR_MODE_READ);

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    next_s = s;
    if (idle)
    begin
      if (addr_high_we)
      begin
        next_s.addr[`FIWR_ADDR_W-1:8] = wdata[`FIWR_ADDR_W-9:0];
      end
      if (addr_low_we)
      begin
        next_s.addr[7:0] = wdata;
        next_s.ptr = wdata[`FIWR_OFS_W-1:0];
      end
      if (data_low_we)
      begin
        next_s.dlo = wdata;
      end
      if (data_high_we)
      begin
        next_s.dhi = wdata;
        next_s.valid[s.ptr] = 1'b1;
        if (s.ptr != `FIWR_LAST_OFS)
        begin
          next_s.ptr = s.ptr + 1'b1;
        end
      end
      if (buffer_clear_set)
      begin
        next_s.valid = '0;
        next_s.ptr = s.addr[`FIWR_OFS_W-1:0];
      end
      if (key_we && s.utimer)
      begin
        unique case (key_idx)
          3'h0: next_s.keys[7:0] = wdata;
          3'h1: next_s.keys[15:8] = wdata;
          3'h2: next_s.keys[23:16] = wdata;
          3'h3: next_s.keys[31:24] = wdata;
          3'h4: next_s.keys[39:32] = wdata;
          3'h5: next_s.keys[47:40] = wdata;
          default: next_s.keys = s.keys;
        endcase
      end
    end

    if (s.utimer)
    begin
      if (s.ucnt == '0)
      begin
        next_s.utimer = 1'b0;
      end
      else
      begin
        next_s.ucnt = s.ucnt - 1'b1;
      end
    end
    else if (idle && unlock_timer_set && op_select_field == `FIWR_MODE_UNLOCK)
    begin
      next_s.utimer = 1'b1;
      next_s.ucnt = UNLOCK_LAST;
      next_s.keys = '0;
    end

    if (unlocked_clear)
    begin
      next_s.unlocked = 1'b0;
    end
    // correct key sets flag, set beats clear
    if (s.utimer && s.keys == `FIWR_KEY_PATTERN)
    begin
      next_s.unlocked = 1'b1;
    end

    unique case (s.st)
      FIWR_IDLE:
      begin
        if (prog_go)
        begin
          next_s.st = FIWR_PROG;
          next_s.cnt = PROG_LAST;
          next_s.idx = '0;
          next_s.ptrig = 1'b1;
        end
        else if (erase_go)
        begin
          next_s.st = FIWR_ERASE;
          next_s.cnt = PROG_LAST;
          next_s.idx = '0;
          next_s.ptrig = 1'b1;
        end
        else if (read_go)
        begin
          next_s.st = FIWR_READ;
          next_s.cnt = READ_LAST;
          next_s.rtrig = 1'b1;
        end
      end
      FIWR_ERASE, FIWR_PROG:
      begin
        if (s.idx != IDX_END)
        begin
          next_s.idx = s.idx + 1'b1;
        end
        // trigger self clears after program time
        if (s.cnt == '0)
        begin
          next_s.st = FIWR_IDLE;
          next_s.ptrig = 1'b0;
        end
        else
        begin
          next_s.cnt = s.cnt - 1'b1;
        end
      end
      FIWR_READ:
      begin
        if (s.cnt == '0)
        begin
          next_s.st = FIWR_IDLE;
          next_s.rtrig = 1'b0;
          next_s.dlo = fl_rdata[7:0];
          next_s.dhi = fl_rdata[15:8];
        end
        else
        begin
          next_s.cnt = s.cnt - 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      s <= '{st: FIWR_IDLE, default: '0};
    end
    else
    begin
      s <= next_s;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign program_trigger_bit = s.ptrig;
  assign read_trigger_bit = s.rtrig;
  assign unlock_timer_bit = s.utimer;
  assign programming_unlocked_flag = s.unlocked;
  assign flash_addr_high_reg = 8'(s.addr[`FIWR_ADDR_W-1:8]);
  assign flash_addr_low_reg = s.addr[7:0];
  assign data_low_byte_reg = s.dlo;
  assign data_high_byte_reg = s.dhi;
  assign cpu_stall = !idle;
  assign fl_erase = (s.st == FIWR_ERASE) && (s.idx == '0);
  // rewrite needs no erase
  // Empty entries are written as zero, which matches the erased state.
  assign fl_prog = (s.st == FIWR_PROG) && (s.idx != '0) && (s.idx != IDX_END);
  assign fl_read = (s.st == FIWR_READ);
  assign fl_wdata = s.valid[word_ofs] ? buf_rdata : 16'h0000;

  always_comb
  begin
    fl_addr = s.addr;
    if (s.st == FIWR_ERASE)
    begin
      fl_addr = {s.addr[`FIWR_ADDR_W-1:`FIWR_OFS_W], `FIWR_OFS_W'(0)};
    end
    else if (s.st == FIWR_PROG)
    begin
      fl_addr = {s.addr[`FIWR_ADDR_W-1:`FIWR_OFS_W], word_ofs};
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  logic [`FIWR_CNT_W-1:0] hi_cnt;

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      hi_cnt <= '0;
    end
    else if (program_trigger_bit)
    begin
      hi_cnt <= hi_cnt + 1'b1;
    end
    else
    begin
      hi_cnt <= '0;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);

  a_locked_trigger: assert property (
    (program_trigger_set && idle && !programming_unlocked_flag)
      |=> !program_trigger_bit && !fl_prog && !fl_erase)
    else $error("Locked trigger was not ignored.");

  a_prog_length: assert property (
    $fell(program_trigger_bit) |-> hi_cnt == `FIWR_CNT_W'(PROG_CYCLES))
    else $error("Program trigger high for wrong time.");

  a_prog_stall: assert property (
    (program_trigger_bit || read_trigger_bit) |-> cpu_stall)
    else $error("CPU not stalled during operation.");

  a_erase_page: assert property (
    fl_erase |-> fl_addr[`FIWR_OFS_W-1:0] == '0 && program_trigger_bit)
    else $error("Erase not on page base.");

  a_prog_burst: assert property (
    $rose(fl_prog) |-> fl_prog[*8] ##0 fl_addr[`FIWR_OFS_W-1:0] == 5'h07)
    else $error("Page words not committed in order.");

  a_read_time: assert property (
    $rose(read_trigger_bit) |-> read_trigger_bit[*3] ##1 !read_trigger_bit)
    else $error("Read trigger length wrong.");

  a_read_unlocked: assert property (
    (read_go && !programming_unlocked_flag) |=> read_trigger_bit)
    else $error("Read refused while locked.");

  a_read_data: assert property (
    $fell(read_trigger_bit) |-> data_low_byte_reg == $past(fl_rdata[7:0])
      && data_high_byte_reg == $past(fl_rdata[15:8]))
    else $error("Read data not captured.");

  a_ptr_hold: assert property (
    (buf_we && s.ptr == `FIWR_LAST_OFS && !buffer_clear_set && !addr_low_we)
      |=> s.ptr == `FIWR_LAST_OFS)
    else $error("Buffer pointer wrapped.");

  a_buf_clear: assert property (
    (idle && buffer_clear_set) |=> s.valid == '0)
    else $error("Buffer clear did not empty buffer.");

  a_unlock_key: assert property (
    $rose(programming_unlocked_flag) |-> $past(unlock_timer_bit)
      && $past(s.keys) == `FIWR_KEY_PATTERN)
    else $error("Unlocked without correct key.");

  c_unlock: cover property ($rose(programming_unlocked_flag));
  c_erase: cover property ($fell(program_trigger_bit) && $past(s.st) == FIWR_ERASE);
  c_write: cover property ($fell(program_trigger_bit) && $past(s.st) == FIWR_PROG);
  c_read: cover property ($fell(read_trigger_bit));

endmodule

// file: verification/fiwr_flash_model.sv
// Behavioural flash array that sits behind the sequencer's flash port.
// Assumes one mclk domain and 13-bit word addresses.
`timescale 1ns/1ps

module fiwr_flash_model
(
  input wire logic mclk,
  input wire logic fl_erase,
  input wire logic fl_prog,
  input wire logic fl_read,
  input wire logic [12:0] fl_addr,
  input wire logic [15:0] fl_wdata,
  output logic [15:0] fl_rdata
);
  logic [15:0] mem [8192];
  logic [15:0] last;

  // ****************
  // Storage
  // ****************
  initial
  begin
    foreach (mem[i])
      mem[i] = 16'hFFFF;
    last = 16'h0000;
  end

  always @(posedge mclk)
  begin
    if (fl_erase)
      for (int i = 0; i < 32; i++)
        mem[{fl_addr[12:5], i[4:0]}] <= 16'h0000;
    if (fl_prog)
      mem[fl_addr] <= fl_wdata;
    if (fl_read)
      last <= mem[fl_addr];
  end

  // Outside a read the port shows the inverse, so a stale word never passes.
  assign fl_rdata = fl_read ? mem[fl_addr] : ~last;
endmodule

// file: verification/tb_fiwr_ctrl.sv
// Self-checking bench for the flash programming sequencer.
// Assumes the package, the controller and the flash model are compiled first.
`timescale 1ns/1ps
`include "fiwr_consts.svh"

module tb_fiwr_ctrl
  import fiwr_pkg::*;
();
  localparam int PROG = 40;
  localparam int UNL = 20;
  localparam logic [12:0] BASE = 13'h04A0;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic [2:0] op_select_field = 3'h0;
  logic read_enable_bit = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [2:0] key_idx = 3'h0;
  logic [9:0] stb = 10'h000;
  logic program_trigger_bit, read_trigger_bit, unlock_timer_bit, programming_unlocked_flag;
  logic [7:0] flash_addr_high_reg, flash_addr_low_reg, data_low_byte_reg, data_high_byte_reg;
  logic cpu_stall, fl_erase, fl_prog, fl_read;
  logic [12:0] fl_addr;
  logic [15:0] fl_wdata, fl_rdata;
  int fails = 0;
  int n_checks = 0;
  int n;
  logic [7:0] key_b [6] = '{8'h00, 8'h0D, 8'hC3, 8'h04, 8'h09, 8'h40};
  logic [15:0] wr_w [3] = '{16'h2211, 16'h4433, 16'h6655};

  always #2 mclk = ~mclk;

  fiwr_ctrl #(.PROG_CYCLES(PROG), .UNLOCK_CYCLES(UNL)) u_fiwr_ctrl (
    .mclk(mclk), .nrst(nrst), .op_select_field(op_select_field),
    .read_enable_bit(read_enable_bit), .wdata(wdata), .addr_high_we(stb[0]),
    .addr_low_we(stb[1]), .data_low_we(stb[2]), .data_high_we(stb[3]), .key_we(stb[4]),
    .key_idx(key_idx), .program_trigger_set(stb[5]), .read_trigger_set(stb[6]),
    .unlock_timer_set(stb[7]), .buffer_clear_set(stb[8]), .unlocked_clear(stb[9]),
    .fl_rdata(fl_rdata), .program_trigger_bit(program_trigger_bit),
    .read_trigger_bit(read_trigger_bit), .unlock_timer_bit(unlock_timer_bit),
    .programming_unlocked_flag(programming_unlocked_flag),
    .flash_addr_high_reg(flash_addr_high_reg), .flash_addr_low_reg(flash_addr_low_reg),
    .data_low_byte_reg(data_low_byte_reg), .data_high_byte_reg(data_high_byte_reg),
    .cpu_stall(cpu_stall), .fl_erase(fl_erase), .fl_prog(fl_prog), .fl_read(fl_read),
    .fl_addr(fl_addr), .fl_wdata(fl_wdata));

  fiwr_flash_model u_fiwr_flash_model (
    .mclk(mclk), .fl_erase(fl_erase), .fl_prog(fl_prog), .fl_read(fl_read),
    .fl_addr(fl_addr), .fl_wdata(fl_wdata), .fl_rdata(fl_rdata));

  // ****************
  // Access tasks
  // ****************
  task automatic final_report();
    if (fails == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic tick();
    @(posedge mclk);
    #1;
  endtask

  task automatic check(input string nm, input logic [15:0] s, input logic [15:0] e);
    n_checks++;
    if (s !== e)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask

  // A strobe is one cycle wide with an idle cycle after it, so no signal is set twice at once.
  task automatic put(input int b, input logic [7:0] v);
    wdata = v;
    stb = 10'h001 << b;
    tick();
    stb = 10'h000;
    tick();
  endtask

  task automatic addr(input logic [12:0] a);
    put(0, {3'h0, a[12:8]});
    put(1, a[7:0]);
  endtask

  function automatic logic sig(input int w);
    return w == 0 ? program_trigger_bit : (w == 1 ? read_trigger_bit : unlock_timer_bit);
  endfunction

  task automatic cnt(input int w, inout int c);
    while (sig(w) === 1'b1 && c < 1000)
    begin
      tick();
      c++;
    end
    if (c >= 1000)
    begin
      fails++;
      final_report();
    end
  endtask

  task automatic rd(input logic [12:0] a, input logic [15:0] e);
    op_select_field = `FIWR_MODE_READ;
    read_enable_bit = 1'b1;
    addr(a);
    put(6, 8'h00);
    check("read stall", {15'h0000, cpu_stall}, 16'h0001);
    n = 1;
    cnt(1, n);
    check("read cycles", n[15:0], 16'h0003);
    check("read data", {data_high_byte_reg, data_low_byte_reg}, e);
  endtask

  task automatic prog(input bit poke);
    put(5, 8'h00);
    check("op stall", {15'h0000, cpu_stall}, 16'h0001);
    n = 1;
    if (poke)
    begin
      put(2, 8'hA5);
      n = 3;
    end
    cnt(0, n);
    check("op cycles", n[15:0], 16'(PROG));
  endtask

  task automatic unl(input bit bad);
    op_select_field = `FIWR_MODE_UNLOCK;
    put(7, 8'h00);
    n = 1;
    for (int i = 0; i < 6; i++)
    begin
      key_idx = i[2:0];
      put(4, key_b[i] ^ {7'h00, bad && i == 5});
      n += 2;
    end
    cnt(2, n);
    check("unlock window", n[15:0], 16'(UNL));
  endtask

  // ****************
  // Main sequence
  // ****************
  initial
  begin
    repeat (16) @(posedge mclk);
    #1;
    nrst = 1'b1;
    check("reset outputs", {11'h000, program_trigger_bit, read_trigger_bit, unlock_timer_bit,
      programming_unlocked_flag, cpu_stall}, 16'h0000);
    rd(BASE, 16'hFFFF);
    read_enable_bit = 1'b0;
    put(6, 8'h00);
    check("read disabled", {14'h0000, read_trigger_bit, cpu_stall}, 16'h0000);
    op_select_field = `FIWR_MODE_WRITE;
    put(5, 8'h00);
    check("locked trigger", {14'h0000, program_trigger_bit, cpu_stall}, 16'h0000);
    unl(1'b1);
    check("bad key", {15'h0000, programming_unlocked_flag}, 16'h0000);
    unl(1'b0);
    check("good key", {15'h0000, programming_unlocked_flag}, 16'h0001);
    op_select_field = `FIWR_MODE_ERASE;
    addr(BASE);
    check("address regs", {flash_addr_high_reg, flash_addr_low_reg}, {3'h0, BASE});
    prog(1'b0);
    rd(BASE, 16'h0000);
    rd(BASE | 13'h001F, 16'h0000);
    op_select_field = `FIWR_MODE_WRITE;
    addr(BASE | 13'h001E);
    for (int i = 0; i < 3; i++)
    begin
      put(2, wr_w[i][7:0]);
      put(3, wr_w[i][15:8]);
    end
    prog(1'b1);
    check("stalled write", {8'h00, data_low_byte_reg}, 16'h0055);
    rd(BASE | 13'h001E, 16'h2211);
    rd(BASE | 13'h001F, 16'h6655);
    rd(BASE, 16'h0000);
    put(8, 8'h00);
    op_select_field = `FIWR_MODE_WRITE;
    addr(BASE | 13'h0001);
    put(2, 8'h99);
    put(3, 8'h88);
    prog(1'b0);
    rd(BASE | 13'h0001, 16'h8899);
    rd(BASE | 13'h001F, 16'h0000);
    put(9, 8'h00);
    check("flag cleared", {15'h0000, programming_unlocked_flag}, 16'h0000);
    op_select_field = `FIWR_MODE_ERASE;
    addr(BASE);
    put(5, 8'h00);
    check("relocked trigger", {15'h0000, program_trigger_bit}, 16'h0000);
    rd(BASE | 13'h0001, 16'h8899);
    final_report();
  end
endmodule
